// [logic/fwq_consts.vh]
// Constants shared by the flash write guard and query host controller.
// Assumes a 125 MHz system clock; every time is in nanoseconds.
`ifndef FWQ_CONSTS_VH
`define FWQ_CONSTS_VH

// System clock period.
`define FWQ_CLK_NS 8

// Bus timing: read access, write pulse, glitch filter, strobe recovery.
`define FWQ_T_ACC_NS 70
`define FWQ_T_WP_NS 35
`define FWQ_T_GLITCH_NS 5
`define FWQ_T_REC_NS 20

// Settling time after the reset pin changes to or from high voltage.
`define FWQ_T_HV_NS 500

// Quiet time after reset before the first write cycle is issued.
`define FWQ_T_PU_NS 1000

// User command codes.
`define FWQ_OP_READ 3'h0
`define FWQ_OP_WRITE 3'h1
`define FWQ_OP_QRY_ENTER 3'h2
`define FWQ_OP_RESET_CMD 3'h3
`define FWQ_OP_QRY_SCAN 3'h4
`define FWQ_OP_UNPROT_ON 3'h5
`define FWQ_OP_UNPROT_OFF 3'h6

// Query entry and reset command bytes and addresses.
`define FWQ_QRY_DATA 16'h0098
`define FWQ_QRY_ADDR_WORD 8'h55
`define FWQ_QRY_ADDR_BYTE 8'haa
`define FWQ_RESET_DATA 16'h00f0

// Query table window captured by a scan, in word addresses.
`define FWQ_TBL_FIRST 8'h10
`define FWQ_TBL_LAST 8'h26
`define FWQ_TBL_DEPTH 23

// Expected query table contents; locations not listed read zero.
`define FWQ_CFI_10 16'h0051
`define FWQ_CFI_11 16'h0052
`define FWQ_CFI_12 16'h0059
`define FWQ_CFI_13 16'h0002
`define FWQ_CFI_15 16'h0040
`define FWQ_CFI_1B 16'h0027
`define FWQ_CFI_1C 16'h0036
`define FWQ_CFI_1F 16'h0004
`define FWQ_CFI_21 16'h000a
`define FWQ_CFI_23 16'h0005
`define FWQ_CFI_25 16'h0004

`endif

// [logic/fwq_tbl_mem.v]
// Small memory holding the query table words captured during a scan.
// Assumes one clock; the read data comes out of a register one cycle late.
`timescale 1ns/1ps
`default_nettype none

module fwq_tbl_mem #(
	parameter DW = 16,
	parameter DEPTH = 23,
	parameter AW = 5
) (
	input wire sys_clk_i,
	input wire rst_i,
	input wire wr_en_i,
	input wire [AW-1:0] wr_addr_i,
	input wire [DW-1:0] wr_data_i,
	input wire [AW-1:0] rd_addr_i,
	output reg [DW-1:0] rd_data_o
);

	// Storage array; contents are undefined until the first scan.
	reg [DW-1:0] mem_q [0:DEPTH-1];

	// Write port; out-of-range indices are dropped.
	always @(posedge sys_clk_i) begin
		if (wr_en_i && (wr_addr_i < DEPTH)) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
	end

	// Registered read port; out-of-range indices read zero.
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= {DW{1'b0}};
		end else if (rd_addr_i < DEPTH) begin
			rd_data_o <= mem_q[rd_addr_i];
		end else begin
			rd_data_o <= {DW{1'b0}};
		end
	end

endmodule

`default_nettype wire

// [logic/fwq_host.v]
// Host controller that drives a parallel NOR flash through its pins for
// write-protect, temporary unprotect and query-table access.
// Assumes the flash data pins are joined outside from dq_o/dq_oe_o/dq_i and
// that an external switch puts high voltage on the reset pin when asked.
//
// How it works
// - High voltage on reset enables temporary unprotect.
// - Write needs chip select, write low, output high.
// - Write 98h to 55h/AAh enters query.
// - Reset command leaves query to array read.
`timescale 1ns/1ps
`default_nettype none
`include "fwq_consts.vh"

module fwq_host #(
	parameter ADDR_W = 20
) (
	input wire sys_clk_i,
	input wire rst_i,
	input wire req_i,
	input wire [2:0] op_i,
	input wire [ADDR_W:0] addr_i,
	input wire [15:0] wdata_i,
	input wire byte_mode_i,
	input wire boot_lock_req_i,
	input wire above_supply_lockout_threshold_i,
	input wire [4:0] tbl_idx_i,
	input wire [15:0] flash_dq_i,
	output reg flash_ce_n_o,
	output reg flash_oe_n_o,
	output reg flash_we_n_o,
	output reg [ADDR_W-1:0] flash_addr_o,
	output reg flash_addr_lsb_o,
	output reg [15:0] flash_dq_o,
	output reg flash_dq_oe_o,
	output reg flash_byte_n_o,
	output reg flash_reset_hv_o,
	output reg boot_lock_accel_input_o,
	output reg busy_o,
	output reg done_o,
	output reg refused_o,
	output reg [15:0] rdata_o,
	output reg cfi_ok_o,
	output wire [15:0] tbl_data_o
);

	// Rounds a least time up to whole cycles, never below one.
	function [7:0] ns2cyc;
		input integer ns;
		integer c;
		begin
			c = (ns + `FWQ_CLK_NS - 1) / `FWQ_CLK_NS;
			if (c < 1) begin
				c = 1;
			end
			ns2cyc = c[7:0];
		end
	endfunction

	// Maps a logical bus address to word pins plus the byte-select pin.
	function [ADDR_W:0] to_pins;
		input [ADDR_W:0] a;
		input bm;
		begin
			if (bm) begin
				to_pins = {a[ADDR_W:1], a[0]};
			end else begin
				to_pins = {a[ADDR_W-1:0], 1'b0};
			end
		end
	endfunction

	// Expected query word for a word address inside the scanned window.
	function [15:0] cfi_exp;
		input [7:0] wa;
		begin
			case (wa)
				8'h10: cfi_exp = `FWQ_CFI_10;
				8'h11: cfi_exp = `FWQ_CFI_11;
				8'h12: cfi_exp = `FWQ_CFI_12;
				8'h13: cfi_exp = `FWQ_CFI_13;
				8'h15: cfi_exp = `FWQ_CFI_15;
				8'h1b: cfi_exp = `FWQ_CFI_1B;
				8'h1c: cfi_exp = `FWQ_CFI_1C;
				8'h1f: cfi_exp = `FWQ_CFI_1F;
				8'h21: cfi_exp = `FWQ_CFI_21;
				8'h23: cfi_exp = `FWQ_CFI_23;
				8'h25: cfi_exp = `FWQ_CFI_25;
				default: cfi_exp = 16'h0000;
			endcase
		end
	endfunction

	// Cycle counts derived from the times; the read pulse covers the two sync stages.
	localparam [7:0] ACC_CYC = ns2cyc(`FWQ_T_ACC_NS) + 8'h02;
	localparam [7:0] WP_CYC = ns2cyc(`FWQ_T_WP_NS);
	localparam [7:0] GL_CYC = ns2cyc(`FWQ_T_GLITCH_NS);
	localparam [7:0] REC_CYC = ns2cyc(`FWQ_T_REC_NS);
	localparam [7:0] HV_CYC = ns2cyc(`FWQ_T_HV_NS);
	localparam [7:0] PU_CYC = ns2cyc(`FWQ_T_PU_NS);
	localparam [7:0] WPULSE = (WP_CYC > GL_CYC) ? WP_CYC : (GL_CYC + 8'h01);
	// Last scan step is the closing reset write; cut to the step counter's width on purpose.
	localparam integer SCAN_END_I = `FWQ_TBL_DEPTH + 1;
	localparam [4:0] SCAN_END = SCAN_END_I[4:0];

	// One-hot sequencer states.
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_ADDR = 6'h02;
	localparam [5:0] ST_PULSE = 6'h04;
	localparam [5:0] ST_RECOV = 6'h08;
	localparam [5:0] ST_HV = 6'h10;
	localparam [5:0] ST_DONE = 6'h20;

	reg [5:0] state_q; // Sequencer state.
	reg [7:0] cnt_q; // Cycles left in the current phase.
	reg [7:0] pu_cnt_q; // Power-up quiet counter.
	reg pu_done_q; // Set once the quiet time after reset has passed.
	reg wr_q; // Current bus cycle is a write.
	reg scan_q; // A query scan is running.
	reg [4:0] step_q; // Scan step: 0 entry, 1..23 reads, 24 reset.
	reg mismatch_q; // Some scanned word differed from its expected value.
	reg bm_q; // Byte mode latched for the running operation.
	reg [15:0] dq_s1_q; // First data synchroniser stage.
	reg [15:0] dq_s2_q; // Second data synchroniser stage.
	reg sup_s1_q; // First supply-good synchroniser stage.
	reg sup_s2_q; // Second supply-good synchroniser stage.
	wire [7:0] scan_wa; // Word address read in the current scan step.
	wire [15:0] rd_masked; // Sampled data, low byte only in byte mode.
	wire [4:0] tbl_widx; // Memory index for the current scan step.
	wire [15:0] scan_exp; // Expected query word for the current scan step.

	assign scan_wa = `FWQ_TBL_FIRST + {3'h0, step_q} - 8'h01;
	assign rd_masked = bm_q ? {8'h00, dq_s2_q[7:0]} : dq_s2_q;
	assign tbl_widx = step_q - 5'h01;
	assign scan_exp = cfi_exp(scan_wa);

	// Captured query words; read data is registered inside the memory.
	fwq_tbl_mem #(
		.DW(16),
		.DEPTH(`FWQ_TBL_DEPTH),
		.AW(5)
	) u_mem (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.wr_en_i(scan_q && state_q == ST_PULSE && cnt_q == 8'h01 && !wr_q),
		.wr_addr_i(tbl_widx),
		.wr_data_i(rd_masked),
		.rd_addr_i(tbl_idx_i),
		.rd_data_o(tbl_data_o)
	);

	// Two-stage synchronisers for pins that come from outside this clock.
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
			sup_s1_q <= 1'b0;
			sup_s2_q <= 1'b0;
		end else begin
			dq_s1_q <= flash_dq_i;
			dq_s2_q <= dq_s1_q;
			sup_s1_q <= above_supply_lockout_threshold_i;
			sup_s2_q <= sup_s1_q;
		end
	end

	// Quiet time after reset; writes issued during power-up would be dropped anyway.
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pu_cnt_q <= 8'h00;
			pu_done_q <= 1'b0;
		end else if (!pu_done_q) begin
			pu_cnt_q <= pu_cnt_q + 8'h01;
			pu_done_q <= (pu_cnt_q + 8'h01 >= PU_CYC);
		end
	end

	// Main sequencer: takes a request in idle, runs bus cycles or a reset-pin change.
	always @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			cnt_q <= 8'h00;
			wr_q <= 1'b0;
			scan_q <= 1'b0;
			step_q <= 5'h00;
			mismatch_q <= 1'b0;
			bm_q <= 1'b0;
			flash_ce_n_o <= 1'b1;
			flash_oe_n_o <= 1'b1;
			flash_we_n_o <= 1'b1;
			flash_addr_o <= {ADDR_W{1'b0}};
			flash_addr_lsb_o <= 1'b0;
			flash_dq_o <= 16'h0000;
			flash_dq_oe_o <= 1'b0;
			flash_byte_n_o <= 1'b1;
			flash_reset_hv_o <= 1'b0;
			boot_lock_accel_input_o <= 1'b0;
			busy_o <= 1'b0;
			done_o <= 1'b0;
			refused_o <= 1'b0;
			rdata_o <= 16'h0000;
			cfi_ok_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			refused_o <= 1'b0;
			// The protect pin follows the user's request; low locks the outer boot sectors.
			boot_lock_accel_input_o <= !boot_lock_req_i;
			case (state_q)
				ST_IDLE: begin
					busy_o <= 1'b0;
					if (req_i) begin
						busy_o <= 1'b1;
						bm_q <= byte_mode_i;
						flash_byte_n_o <= !byte_mode_i;
						wr_q <= (op_i != `FWQ_OP_READ);
						scan_q <= (op_i == `FWQ_OP_QRY_SCAN);
						step_q <= 5'h00;
						mismatch_q <= 1'b0;
						if (op_i == `FWQ_OP_UNPROT_ON || op_i == `FWQ_OP_UNPROT_OFF) begin
							// Leaving high voltage makes the device re-protect by itself.
							flash_reset_hv_o <= (op_i == `FWQ_OP_UNPROT_ON);
							cnt_q <= HV_CYC;
							state_q <= ST_HV;
						end else if (op_i != `FWQ_OP_READ && (!sup_s2_q || !pu_done_q)) begin
							// No write is attempted below lockout or during power-up.
							refused_o <= 1'b1;
							state_q <= ST_DONE;
						end else if (op_i > `FWQ_OP_UNPROT_OFF) begin
							refused_o <= 1'b1;
							state_q <= ST_DONE;
						end else begin
							flash_ce_n_o <= 1'b0;
							flash_dq_oe_o <= (op_i != `FWQ_OP_READ);
							state_q <= ST_ADDR;
							if (op_i == `FWQ_OP_QRY_ENTER || op_i == `FWQ_OP_QRY_SCAN) begin
								// Query entry address depends on the bus width.
								{flash_addr_o, flash_addr_lsb_o} <= to_pins(byte_mode_i ?
									{{(ADDR_W-7){1'b0}}, `FWQ_QRY_ADDR_BYTE} :
									{{(ADDR_W-7){1'b0}}, `FWQ_QRY_ADDR_WORD}, byte_mode_i);
								flash_dq_o <= `FWQ_QRY_DATA;
							end else if (op_i == `FWQ_OP_RESET_CMD) begin
								// The reset command drops query mode to its former mode.
								{flash_addr_o, flash_addr_lsb_o} <= {(ADDR_W+1){1'b0}};
								flash_dq_o <= `FWQ_RESET_DATA;
							end else begin
								{flash_addr_o, flash_addr_lsb_o} <= to_pins(addr_i, byte_mode_i);
								flash_dq_o <= wdata_i;
							end
						end
					end
				end
				ST_ADDR: begin
					// Address and select settle for one cycle before any strobe falls.
					if (wr_q) begin
						flash_we_n_o <= 1'b0;
						flash_oe_n_o <= 1'b1;
						cnt_q <= WPULSE;
					end else begin
						flash_oe_n_o <= 1'b0;
						flash_we_n_o <= 1'b1;
						cnt_q <= ACC_CYC;
					end
					state_q <= ST_PULSE;
				end
				ST_PULSE: begin
					if (cnt_q == 8'h01) begin
						flash_we_n_o <= 1'b1;
						flash_oe_n_o <= 1'b1;
						cnt_q <= REC_CYC;
						state_q <= ST_RECOV;
						if (!wr_q) begin
							rdata_o <= rd_masked;
							if (scan_q && rd_masked != (bm_q ? {8'h00, scan_exp[7:0]} :
								scan_exp)) begin
								mismatch_q <= 1'b1;
							end
						end
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				ST_RECOV: begin
					// Data is held through recovery; the strobe is already high.
					if (cnt_q == 8'h01) begin
						flash_dq_oe_o <= 1'b0;
						if (scan_q && step_q != SCAN_END) begin
							step_q <= step_q + 5'h01;
							state_q <= ST_ADDR;
							if (step_q + 5'h01 == SCAN_END) begin
								wr_q <= 1'b1;
								flash_dq_oe_o <= 1'b1;
								flash_dq_o <= `FWQ_RESET_DATA;
								{flash_addr_o, flash_addr_lsb_o} <= {(ADDR_W+1){1'b0}};
							end else begin
								wr_q <= 1'b0;
								// Byte mode reads each location at twice its word address.
								{flash_addr_o, flash_addr_lsb_o} <= to_pins(bm_q ?
									{{(ADDR_W-8){1'b0}}, scan_wa + 8'h01, 1'b0} :
									{{(ADDR_W-7){1'b0}}, scan_wa + 8'h01}, bm_q);
							end
						end else begin
							flash_ce_n_o <= 1'b1;
							if (scan_q) begin
								cfi_ok_o <= !mismatch_q;
							end
							state_q <= ST_DONE;
						end
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				ST_HV: begin
					// Wait for the reset pin to settle at its new level.
					if (cnt_q == 8'h01) begin
						state_q <= ST_DONE;
					end else begin
						cnt_q <= cnt_q - 8'h01;
					end
				end
				ST_DONE: begin
					done_o <= 1'b1;
					busy_o <= 1'b0;
					scan_q <= 1'b0;
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule

`default_nettype wire

// [bench/fwq_host_assertions.sv]
// Concurrent checks on the pins of the flash write guard and query host.
// Assumes binding into every fwq_host; it sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module fwq_host_chk #(
	parameter ADDR_W = 20
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic boot_lock_req_i,
	input wire logic flash_ce_n_o,
	input wire logic flash_oe_n_o,
	input wire logic flash_we_n_o,
	input wire logic [ADDR_W-1:0] flash_addr_o,
	input wire logic flash_addr_lsb_o,
	input wire logic [15:0] flash_dq_o,
	input wire logic flash_dq_oe_o,
	input wire logic flash_byte_n_o,
	input wire logic flash_reset_hv_o,
	input wire logic boot_lock_accel_input_o,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic refused_o,
	input wire logic cfi_ok_o
);
	// One clock domain, so the clock and reset are given once.
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// A write strobe falling with the reset command byte on the bus.
	sequence f0_beat_s;
		$fell(flash_we_n_o) && flash_dq_o[7:0] == 8'hf0;
	endsequence
	write_window_a: assert property (
		!flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && flash_dq_oe_o)
		else $error("write strobe outside a legal write window");
	read_window_a: assert property (
		!flash_oe_n_o |-> !flash_ce_n_o && flash_we_n_o && !flash_dq_oe_o)
		else $error("read strobe outside a legal read window");
	wpulse_len_a: assert property (
		$fell(flash_we_n_o) |-> !flash_we_n_o [*5] ##1 flash_we_n_o)
		else $error("write pulse length wrong");
	qry_entry_a: assert property (
		!flash_we_n_o && flash_dq_o[7:0] == 8'h98 |->
		flash_addr_o[7:0] == 8'h55 && (flash_byte_n_o || !flash_addr_lsb_o))
		else $error("query command sent to the wrong address");
	qry_exit_a: assert property (
		$fell(flash_we_n_o) && flash_dq_o[7:0] == 8'h98 |-> ##[1:600] f0_beat_s)
		else $error("query mode not left by a reset command");
	hv_busy_a: assert property ($changed(flash_reset_hv_o) |-> busy_o)
		else $error("high voltage changed outside an operation");
	lock_pin_a: assert property (
		!$past(rst_i) |-> boot_lock_accel_input_o == !$past(boot_lock_req_i))
		else $error("protect pin does not follow the lock request");
	refuse_done_a: assert property (refused_o |=> done_o && !refused_o)
		else $error("refusal not followed by done");
	// Main scenarios that the bench is meant to reach.
	cover property (refused_o);
	cover property ($rose(flash_reset_hv_o));
	cover property (done_o && cfi_ok_o);
endmodule
bind fwq_host fwq_host_chk #(.ADDR_W(ADDR_W)) u_fwq_host_chk (.*);
`default_nettype wire

// [bench/fwq_flash_model.sv]
// Behavioural model of the flash pins: array, write guard, query table.
// Assumes the host holds strobes for many ns; a top-boot part by default.
`timescale 1ns/1ps
`default_nettype none
module fwq_flash_model #(
	parameter bit TOP_BOOT = 1'b1
) (
	input wire logic ce_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	input wire logic [19:0] addr_i,
	input wire logic lsb_i,
	input wire logic [15:0] dq_i,
	input wire logic byte_n_i,
	input wire logic hv_i,
	input wire logic wp_n_i,
	input wire logic supply_i,
	input wire logic bad_i,
	output wire logic [15:0] dq_o
);
	logic qry_q = 1'b0; // Query mode; power-up reads the array.
	logic [15:0] mem_q [0:15] = '{default: 16'h0000}; // Aliased tiny array, top bit split off.
	logic [15:0] last_q = 16'h0000; // Last word driven, inverted when released.
	realtime t_fall = 0.0; // Time the write strobe last fell.
	logic [15:0] val; // Word presented on a read.
	logic boot; // Address lies in one of the two outer boot sectors.
	assign boot = TOP_BOOT ? &addr_i[19:13] : ~|addr_i[19:13];
	function automatic logic [15:0] cfi_val(input logic [7:0] a);
		case (a)
			8'h10: cfi_val = 16'h0051;
			8'h11: cfi_val = 16'h0052;
			8'h12: cfi_val = 16'h0059;
			8'h13: cfi_val = 16'h0002;
			8'h15: cfi_val = 16'h0040;
			8'h1b: cfi_val = 16'h0027;
			8'h1c: cfi_val = 16'h0036;
			8'h1f: cfi_val = 16'h0004;
			8'h21: cfi_val = 16'h000a;
			8'h23: cfi_val = 16'h0005;
			8'h25: cfi_val = 16'h0004;
			default: cfi_val = 16'h0000;
		endcase
	endfunction
	// Read value; a commanded fault flips bit 0 so a scan must fail.
	always @* begin
		val = qry_q ? cfi_val(addr_i[7:0]) : mem_q[{addr_i[19], addr_i[2:0]}];
		if (!byte_n_i) val = {8'h00, val[7:0]};
		if (bad_i) val = val ^ 16'h0001;
	end
	// Released pins show the inverse, so a stale value never passes.
	assign dq_o = (!ce_n_i && !oe_n_i) ? val : ~last_q;
	always @(posedge oe_n_i) last_q <= val;
	always @(negedge we_n_i) t_fall = $realtime;
	// Commands and data are taken on the rising write strobe.
	always @(posedge we_n_i) begin
		if (!ce_n_i && oe_n_i && supply_i && ($realtime - t_fall >= 5.0)) begin
			if (dq_i[7:0] == 8'h98 && addr_i[7:0] == 8'h55 && (byte_n_i || !lsb_i)) qry_q <= 1'b1;
			else if (dq_i[7:0] == 8'hf0) qry_q <= 1'b0;
			else if (!qry_q && (!boot || (wp_n_i && hv_i))) mem_q[{addr_i[19], addr_i[2:0]}] <= dq_i;
		end
	end
	always @(negedge supply_i) qry_q <= 1'b0;
endmodule
`default_nettype wire

// [bench/test_fwq_host.sv]
// Self-checking bench for the flash write guard and query host.
// Assumes the flash model on the far side; 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "fwq_consts.vh"
module test_fwq_host;
	logic sys_clk_i, rst_i, req_i, byte_mode_i, boot_lock_req_i, bad, ref_seen;
	logic above_supply_lockout_threshold_i;
	logic [2:0] op_i;
	logic [20:0] addr_i;
	logic [15:0] wdata_i;
	logic [4:0] tbl_idx_i;
	wire logic [15:0] flash_dq_i, flash_dq_o, rdata_o, tbl_data_o, mdl_dq;
	wire logic [19:0] flash_addr_o;
	wire logic flash_ce_n_o, flash_oe_n_o, flash_we_n_o, flash_addr_lsb_o, flash_dq_oe_o;
	wire logic flash_byte_n_o, flash_reset_hv_o, boot_lock_accel_input_o, busy_o, done_o;
	wire logic refused_o, cfi_ok_o;
	int miscompares = 0;
	int tests_run = 0;
	// The shared data wire: whoever enables drives it.
	assign flash_dq_i = flash_dq_oe_o ? flash_dq_o : mdl_dq;
	fwq_host u_fwq_host (.*);
	fwq_flash_model u_fwq_flash_model (.ce_n_i(flash_ce_n_o), .oe_n_i(flash_oe_n_o),
		.we_n_i(flash_we_n_o), .addr_i(flash_addr_o), .lsb_i(flash_addr_lsb_o),
		.dq_i(flash_dq_o), .byte_n_i(flash_byte_n_o), .hv_i(flash_reset_hv_o),
		.wp_n_i(boot_lock_accel_input_o), .supply_i(above_supply_lockout_threshold_i),
		.bad_i(bad), .dq_o(mdl_dq));
	initial begin
		sys_clk_i = 1'b0;
		forever #4 sys_clk_i = ~sys_clk_i;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0s expected %h seen %h", nm, e, g);
		end
	endtask
	// One request, then a bounded wait for done; a refusal is remembered.
	task automatic op(input logic [2:0] o, input logic [20:0] a, input logic [15:0] d, input logic bm);
		int n;
		@(posedge sys_clk_i);
		req_i <= 1'b1;
		op_i <= o;
		addr_i <= a;
		wdata_i <= d;
		byte_mode_i <= bm;
		@(posedge sys_clk_i);
		req_i <= 1'b0;
		ref_seen = 1'b0;
		// The refusal pulse stands in the cycle after the take edge, so look there first.
		for (n = 0; n < 3000; n++) begin
			#1;
			if (refused_o === 1'b1) ref_seen = 1'b1;
			if (done_o === 1'b1) break;
			@(posedge sys_clk_i);
		end
		if (n >= 3000) begin
			miscompares++;
			report_and_stop();
		end
	endtask
	task automatic wr_rd(input string nm, input logic [20:0] a, input logic [15:0] d, e);
		op(`FWQ_OP_WRITE, a, d, 1'b0);
		op(`FWQ_OP_READ, a, 16'h0000, 1'b0);
		chk(nm, e, rdata_o);
	endtask
	task automatic t_power_up;
		op(`FWQ_OP_WRITE, 21'h1, 16'h1234, 1'b0);
		chk("early write refused", 16'h0001, {15'h0, ref_seen});
		repeat (130) @(posedge sys_clk_i);
		wr_rd("array write", 21'h1, 16'h1234, 16'h1234);
		$display("t_power_up done");
	endtask
	task automatic t_query;
		op(`FWQ_OP_QRY_SCAN, 21'h0, 16'h0000, 1'b0);
		chk("word scan", 16'h0001, {15'h0, cfi_ok_o});
		for (int i = 0; i < 23; i++) begin
			@(posedge sys_clk_i);
			tbl_idx_i <= i[4:0];
			@(posedge sys_clk_i);
			#1;
			chk("table", u_fwq_flash_model.cfi_val(8'h10 + i[7:0]), tbl_data_o);
		end
		op(`FWQ_OP_QRY_SCAN, 21'h0, 16'h0000, 1'b1);
		chk("byte scan", 16'h0001, {15'h0, cfi_ok_o});
		@(posedge sys_clk_i) bad <= 1'b1;
		op(`FWQ_OP_QRY_SCAN, 21'h0, 16'h0000, 1'b0);
		chk("corrupt scan", 16'h0000, {15'h0, cfi_ok_o});
		@(posedge sys_clk_i) bad <= 1'b0;
		op(`FWQ_OP_QRY_ENTER, 21'h0, 16'h0000, 1'b0);
		op(`FWQ_OP_READ, 21'h10, 16'h0000, 1'b0);
		chk("query id", 16'h0051, rdata_o);
		op(`FWQ_OP_RESET_CMD, 21'h0, 16'h0000, 1'b0);
		op(`FWQ_OP_READ, 21'h1, 16'h0000, 1'b0);
		chk("array after reset", 16'h1234, rdata_o);
		$display("t_query done");
	endtask
	// Boot word in the top outer sector, which powers up protected.
	task automatic t_protect;
		@(posedge sys_clk_i) boot_lock_req_i <= 1'b1;
		wr_rd("boot locked", 21'hff000, 16'h00a5, 16'h0000);
		wr_rd("other sector", 21'h2, 16'h0042, 16'h0042);
		@(posedge sys_clk_i) boot_lock_req_i <= 1'b0;
		wr_rd("stored protect", 21'hff000, 16'h00a5, 16'h0000);
		op(`FWQ_OP_UNPROT_ON, 21'h0, 16'h0000, 1'b0);
		wr_rd("temp unprotect", 21'hff000, 16'h00a5, 16'h00a5);
		@(posedge sys_clk_i) boot_lock_req_i <= 1'b1;
		wr_rd("lock wins", 21'hff000, 16'h0077, 16'h00a5);
		@(posedge sys_clk_i) boot_lock_req_i <= 1'b0;
		op(`FWQ_OP_UNPROT_OFF, 21'h0, 16'h0000, 1'b0);
		wr_rd("protect restored", 21'hff000, 16'h0033, 16'h00a5);
		$display("t_protect done");
	endtask
	task automatic t_supply;
		@(posedge sys_clk_i) above_supply_lockout_threshold_i <= 1'b0;
		repeat (4) @(posedge sys_clk_i);
		op(`FWQ_OP_WRITE, 21'h1, 16'hdead, 1'b0);
		chk("low supply refused", 16'h0001, {15'h0, ref_seen});
		op(`FWQ_OP_READ, 21'h1, 16'h0000, 1'b0);
		chk("low supply data kept", 16'h1234, rdata_o);
		@(posedge sys_clk_i) above_supply_lockout_threshold_i <= 1'b1;
		$display("t_supply done");
	endtask
	initial begin
		{rst_i, req_i, byte_mode_i, boot_lock_req_i, bad} = 5'b10000;
		above_supply_lockout_threshold_i = 1'b1;
		{op_i, addr_i, wdata_i, tbl_idx_i} = '0;
		repeat (12) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		t_power_up();
		t_query();
		t_protect();
		t_supply();
		report_and_stop();
	end
endmodule
`default_nettype wire
